/* test_mode_and_scan_control_tb.sv */
// Self-checking bench for the test-mode and scan control block
`timescale 1ns/1ps
module test_mode_and_scan_control_tb;
  import tmsc_pkg::*;
  localparam logic [31:0] ID = 32'h5a3c0f01;  // Arbitrary code, lsb set
  logic                  mclk = 1'b0;
  logic                  rst = 1'b1;
  logic [1:0]            sel = SEL_NORMAL;  // Board holds selector low
  logic [NAND_WIDTH-1:0] pin = '0;
  logic [OUT_WIDTH-1:0]  cout = '0;
  logic [OUT_WIDTH-1:0]  coe = '0;
  logic                  cscl = 1'b0;
  logic                  csoe = 1'b0;
  logic [OUT_WIDTH-1:0]  pad, poe;
  logic                  scl, soe, tck, tdi, tms, tmsd, trst_n, tdo, tdo_oe, nmode;
  int                    bad_count = 0;
  int                    n_checks = 0;
  int                    cyc = 0;

  always #50 mclk = ~mclk;

  tmsc_top #(.ID_CODE(ID)) dut_u (
    .MCLK(mclk), .SYS_RST(rst), .TEST_MODE_SELECT(sel), .PIN_IN(pin), .CORE_OUT(cout),
    .CORE_OE(coe), .CORE_SCL_OUT(cscl), .CORE_SCL_OE(csoe), .PAD_OUT(pad), .PAD_OE(poe),
    .SCL_OUT(scl), .SCL_OE(soe), .TCK(tck), .TDI(tdi), .TMS(tms), .TMS_DRIVEN(tmsd),
    .TRST_N(trst_n), .TDO(tdo), .TDO_OE(tdo_oe), .NAND_MODE(nmode)
  );
  tmsc_board_model bm_u (
    .MCLK(mclk), .TCK(tck), .TDI(tdi), .TMS(tms), .TMS_DRIVEN(tmsd), .TRST_N(trst_n), .TDO(tdo)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Reset for 20 cycles with a given selector
  task automatic do_reset(input logic [1:0] s);
    @(negedge mclk);
    rst = 1'b1;
    sel = s;
    wait_n(20);
    rst = 1'b0;
    wait_n(2);
  endtask

  // Run n scan periods, select and data bits lsb first
  task automatic seq(input logic [39:0] m, input logic [39:0] d, input logic drv, input int n,
                     output logic [39:0] got);
    got = '0;
    for (int i = 0; i < n; i++) begin
      bm_u.step(m[i], drv, d[i], got[i]);
    end
  endtask

  // Every selector code, pads and serial clock
  task automatic t_modes();
    logic [3:0] tree_tbl;
    tree_tbl = 4'b1000;  // Only code 11 selects the tree
    for (int c = 0; c < 4; c++) begin
      do_reset(2'(c));
      cout = 16'ha5c3 ^ 16'(c);
      coe = 16'h0ff0;
      cscl = c[0];
      csoe = ~c[1];
      wait_n(2);
      chk(nmode, tree_tbl[c]);
      chk(poe, tree_tbl[c] ? 16'h0000 : 16'h0ff0);
      chk(pad, tree_tbl[c] ? 16'h0000 : 16'ha5c3 ^ 16'(c));
      chk(soe, tree_tbl[c] ? 1'b1 : csoe);
      chk(scl, tree_tbl[c] ? 1'b1 : cscl);  // All-low pins give a high tree result
    end
    $display("test modes done");
  endtask

  // Tree result on the serial clock pin
  task automatic t_tree();
    logic [15:0] vin [4];
    logic        vexp [4];
    logic [39:0] got;
    vin = '{16'hffff, 16'h0000, 16'hbfff, 16'hfffe};
    vexp = '{1'b0, 1'b1, 1'b0, 1'b1};
    do_reset(SEL_NAND);
    for (int i = 0; i < 4; i++) begin
      pin = vin[i];
      wait_n(2);
      chk(scl, vexp[i]);
    end
    seq(40'h06, 40'h0, 1'b1, 6, got);  // Into instruction shift, one shifting fall
    chk(tdo_oe, 1'b0);
    $display("test tree done");
  endtask

  // Selector change alone keeps the mode
  task automatic t_hold();
    sel = SEL_NORMAL;
    wait_n(5);
    chk(nmode, 1'b1);
    do_reset(SEL_NORMAL);
    chk(nmode, 1'b0);
    $display("test hold done");
  endtask

  // Instruction capture, pull-up reset, identification, sample and bypass reads, scan reset
  task automatic t_scan();
    logic [39:0] got;
    bm_u.trst();
    seq(40'h0df, 40'h0, 1'b1, 10, got);
    seq(40'h8, 40'h0, 1'b1, 4, got);
    chk(got[3:0], IR_CAPTURE);
    chk(tdo_oe, 1'b1);
    seq(40'h0, 40'h0, 1'b0, 5, got);
    chk(tdo_oe, 1'b0);
    seq(40'h2, 40'h0, 1'b1, 4, got);
    seq(40'h80000000, 40'h0, 1'b1, 32, got);
    chk(got[31:0], ID);
    seq(40'h07, 40'h0, 1'b1, 5, got);
    seq(40'h8, 40'(INS_SAMPLE), 1'b1, 4, got);
    seq(40'h3, 40'h0, 1'b1, 4, got);
    seq(40'h8000, 40'h0, 1'b1, 16, got);
    chk(got[15:0], pin);
    seq(40'h07, 40'h0, 1'b1, 5, got);
    seq(40'h8, 40'(INS_BYPASS), 1'b1, 4, got);
    seq(40'h3, 40'h0, 1'b1, 4, got);
    seq(40'h10, 40'h0b, 1'b1, 5, got);
    chk(got[4:0], 5'h16);  // Captured zero, then data delayed by one
    chk(tdo_oe, 1'b1);
    bm_u.trst();
    chk(tdo_oe, 1'b0);
    $display("test scan done");
  endtask

  initial begin
    t_modes();
    t_tree();
    t_hold();
    t_scan();
    results();
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("timeout at cycle %0d", cyc);
      results();
    end
  end
endmodule

/* tmsc_board_model.sv */
// Board test equipment model driving the scan pins
`timescale 1ns/1ps
module tmsc_board_model (
  // Board clock
  input  wire logic MCLK,
  // Scan drive
  output logic      TCK,
  output logic      TDI,
  output logic      TMS,
  output logic      TMS_DRIVEN,
  output logic      TRST_N,
  // Scan return
  input  wire logic TDO
);
  // Idle levels
  initial begin
    TCK = 1'b0;
    TDI = 1'b0;
    TMS = 1'b0;
    TMS_DRIVEN = 1'b1;
    TRST_N = 1'b1;
  end

  // Scan reset held four board clocks
  task automatic trst();
    @(negedge MCLK);
    TRST_N = 1'b0;
    repeat (4) @(negedge MCLK);
    TRST_N = 1'b1;
  endtask

  // One scan clock period: fall, sample, rise
  task automatic step(input logic m, input logic drv, input logic d, output logic o);
    @(negedge MCLK);
    TCK = 1'b0;
    TMS = drv ? m : 1'b0;  // Undriven line shows low, pull-up is internal
    TMS_DRIVEN = drv;
    TDI = d;  // Data bit for this period
    repeat (3) @(negedge MCLK);
    o = TDO;  // Settled two flops after the fall
    TCK = 1'b1;
    repeat (2) @(negedge MCLK);
  endtask
endmodule

/* tmsc_chk.sv */
// Concurrent checks on the test-mode and scan control ports
`timescale 1ns/1ps
module tmsc_chk
  import tmsc_pkg::*;
(
  // Clock and reset
  input wire logic                  MCLK,
  input wire logic                  SYS_RST,
  // Mode selector and pins
  input wire logic [1:0]            TEST_MODE_SELECT,
  input wire logic [NAND_WIDTH-1:0] PIN_IN,
  input wire logic [OUT_WIDTH-1:0]  CORE_OUT,
  input wire logic [OUT_WIDTH-1:0]  CORE_OE,
  input wire logic [OUT_WIDTH-1:0]  PAD_OUT,
  input wire logic [OUT_WIDTH-1:0]  PAD_OE,
  input wire logic                  SCL_OUT,
  input wire logic                  SCL_OE,
  input wire logic                  NAND_MODE,
  // Scan port
  input wire logic                  TCK,
  input wire logic                  TMS,
  input wire logic                  TMS_DRIVEN,
  input wire logic                  TRST_N,
  input wire logic                  TDO_OE
);
  logic tck_q;  // Last scan clock sample
  logic tms_q;  // Effective mode select at last rise

  // Tree result worked out independently
  function automatic logic tree_f(input logic [NAND_WIDTH-1:0] p);
    logic s;
    s = p[0];
    for (int i = 1; i < NAND_WIDTH; i++) s = ~(s & p[i]);
    return s;
  endfunction

  // Track the select level seen at each scan clock rise
  always_ff @(posedge MCLK) begin
    tck_q <= TCK;
    if (SYS_RST) begin
      tms_q <= 1'b1;
    end else if (TCK && !tck_q) begin
      tms_q <= TMS_DRIVEN ? TMS : 1'b1;  // Undriven reads high
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence s_release;
    $past(SYS_RST) && !SYS_RST;
  endsequence
  sequence s_trst;
    !TRST_N [*4];
  endsequence

  property p_nand_tri;
    NAND_MODE |-> PAD_OE == '0 && PAD_OUT == '0;
  endproperty
  property p_nand_scl;
    NAND_MODE |-> SCL_OE;
  endproperty
  property p_nand_tdo;
    NAND_MODE |-> !TDO_OE;
  endproperty
  property p_scl_tree;
    NAND_MODE && !$past(SYS_RST) |-> SCL_OUT == tree_f($past(PIN_IN));
  endproperty
  property p_capture;
    s_release |=> NAND_MODE == ($past(TEST_MODE_SELECT, 2) == SEL_NAND);
  endproperty
  property p_hold;
    !$past(SYS_RST) && !$past(SYS_RST, 2) |-> $stable(NAND_MODE);
  endproperty
  property p_pad_follow;
    !NAND_MODE && !$past(SYS_RST) |-> PAD_OUT == $past(CORE_OUT) && PAD_OE == $past(CORE_OE);
  endproperty
  property p_oe_tms;
    $rose(TDO_OE) |-> !tms_q;
  endproperty
  property p_trst;
    s_trst |-> !TDO_OE;
  endproperty

  a_nand_tri: assert property (p_nand_tri) else $error("pads driven in tree mode");
  a_nand_scl: assert property (p_nand_scl) else $error("serial clock off in tree mode");
  a_nand_tdo: assert property (p_nand_tdo) else $error("scan out driven in tree mode");
  a_scl_tree: assert property (p_scl_tree) else $error("serial clock not tree result");
  a_capture: assert property (p_capture) else $error("mode not taken from selector");
  a_hold: assert property (p_hold) else $error("mode changed without reset");
  a_pad_follow: assert property (p_pad_follow) else $error("pads not following core");
  a_oe_tms: assert property (p_oe_tms) else $error("shift entered with select high");
  a_trst: assert property (p_trst) else $error("scan out driven under scan reset");
endmodule

bind tmsc_top tmsc_chk chk_u (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .TEST_MODE_SELECT(TEST_MODE_SELECT), .PIN_IN(PIN_IN),
  .CORE_OUT(CORE_OUT), .CORE_OE(CORE_OE), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE),
  .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .NAND_MODE(NAND_MODE), .TCK(TCK), .TMS(TMS),
  .TMS_DRIVEN(TMS_DRIVEN), .TRST_N(TRST_N), .TDO_OE(TDO_OE)
);

/* tmsc_nand_tree.sv */
// NAND-tree chain over the tested input pins
`timescale 1ns/1ps
module tmsc_nand_tree (
  // Pins under test
  input  wire logic [tmsc_pkg::NAND_WIDTH-1:0] nand_in,
  // Chain result
  output wire logic                            nand_out
);
  import tmsc_pkg::*;

  logic [NAND_WIDTH-1:0] stage;                         // Running value along the chain

  // First stage is the first pin itself
  assign stage[0] = nand_in[0];

  // Each later pin is NANDed with the previous stage; with later pins high, a pin flips the end only while the stage before it is high
  genvar i;
  generate
    for (i = 1; i < NAND_WIDTH; i = i + 1) begin : g_chain
      assign stage[i] = ~(stage[i-1] & nand_in[i]);
    end
  endgenerate

  // Last stage leaves the tree
  assign nand_out = stage[NAND_WIDTH-1];

endmodule

/* tmsc_pkg.sv */
// Constants, encodings and state types for the test-mode and scan control block
//
// Overview of operation
// - NAND-tree mode tristates all outputs except serial clock
// - Serial clock pin carries NAND-tree result in test
// - Two-bit test-mode selector captured during reset
// - Mode held until selector changes and reset
// - 00 normal, 11 NAND tree, 01/10 reserved
// - Boundary-scan port: clock, data in/out, mode, reset
// - Mode select pulled high keeps controller reset
package tmsc_pkg;

  // Pin counts of the tested pad ring
  localparam int unsigned NAND_WIDTH   = 16;            // Inputs feeding the NAND tree
  localparam int unsigned OUT_WIDTH    = 16;            // Ordinary outputs that get tristated

  // Test-mode selector encodings
  localparam logic [1:0]  SEL_NORMAL   = 2'h0;          // Normal operation
  localparam logic [1:0]  SEL_RSVD_A   = 2'h1;          // Reserved
  localparam logic [1:0]  SEL_RSVD_B   = 2'h2;          // Reserved
  localparam logic [1:0]  SEL_NAND     = 2'h3;          // NAND tree, outputs tristated

  // Operating mode after capture
  typedef enum logic {
    MODE_NORMAL,
    MODE_NAND
  } tmsc_mode_e;

  // Scan instruction register
  localparam int unsigned IR_WIDTH     = 4;             // Instruction register length
  localparam int unsigned ID_WIDTH     = 32;            // Identification register length
  localparam logic [3:0]  INS_SAMPLE   = 4'h1;          // Capture input pins into boundary chain
  localparam logic [3:0]  INS_IDCODE   = 4'h2;          // Select identification register
  localparam logic [3:0]  INS_BYPASS   = 4'hf;          // Single-bit bypass
  localparam logic [3:0]  IR_CAPTURE   = 4'h1;          // Fixed pattern loaded in capture-IR

  // Scan controller states
  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } tmsc_tap_e;

endpackage

/* tmsc_top.sv */
// Test-mode capture, output tristate control and boundary-scan controller
`timescale 1ns/1ps
module tmsc_top #(
  parameter logic [tmsc_pkg::ID_WIDTH-1:0] ID_CODE = 32'h00000001  // Arbitrary value, lsb set
) (
  // Clock and reset
  input  wire logic                            MCLK,
  input  wire logic                            SYS_RST,
  // Test-mode selector pins
  input  wire logic [1:0]                      TEST_MODE_SELECT,
  // Input pins seen by the NAND tree and boundary chain
  input  wire logic [tmsc_pkg::NAND_WIDTH-1:0] PIN_IN,
  // Functional outputs from the core
  input  wire logic [tmsc_pkg::OUT_WIDTH-1:0]  CORE_OUT,
  input  wire logic [tmsc_pkg::OUT_WIDTH-1:0]  CORE_OE,
  input  wire logic                            CORE_SCL_OUT,
  input  wire logic                            CORE_SCL_OE,
  // Pad drive towards the pins
  output logic      [tmsc_pkg::OUT_WIDTH-1:0]  PAD_OUT,
  output logic      [tmsc_pkg::OUT_WIDTH-1:0]  PAD_OE,
  output logic                                 SCL_OUT,
  output logic                                 SCL_OE,
  // Boundary-scan port
  input  wire logic                            TCK,
  input  wire logic                            TDI,
  input  wire logic                            TMS,
  input  wire logic                            TMS_DRIVEN,
  input  wire logic                            TRST_N,
  output logic                                 TDO,
  output logic                                 TDO_OE,
  // Mode status
  output logic                                 NAND_MODE
);
  import tmsc_pkg::*;

  // Mode capture
  tmsc_mode_e             mode_q;                       // Operating mode fixed at reset
  logic                   nand_act;                     // NAND-tree mode in force
  logic                   nand_res;                     // Tree result

  // Scan clock edge detection
  logic                   tck_q;                        // Previous sample of the scan clock
  logic                   tck_rise;                     // Rising edge seen this cycle
  logic                   tck_fall;                     // Falling edge seen this cycle

  // Scan controller
  logic                   tap_rst;                      // Controller reset condition
  logic                   tms_eff;                      // Mode select after the pull-up
  tmsc_tap_e              state_q;                      // Controller state
  tmsc_tap_e              state_d;                      // Next controller state
  logic [IR_WIDTH-1:0]    ir_sr_q;                      // Instruction shift stage
  logic [IR_WIDTH-1:0]    ir_q;                         // Active instruction
  logic [ID_WIDTH-1:0]    id_sr_q;                      // Identification shift register
  logic [NAND_WIDTH-1:0]  bsr_q;                        // Boundary chain over input pins
  logic                   byp_q;                        // Bypass bit
  logic                   dr_bit;                       // Serial out of selected data register
  logic                   tdo_val_q;                    // Serial out value, set on falling edge
  logic                   tdo_en_q;                     // Shifting in progress, set on falling edge

  // NAND tree over the input pins
  tmsc_nand_tree u_tree (
    .nand_in  (PIN_IN),
    .nand_out (nand_res)
  );

  // Selector is sampled on every clock while reset is high; last sample stands
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      if (TEST_MODE_SELECT == SEL_NAND) begin
        mode_q <= MODE_NAND;
      end else begin
        mode_q <= MODE_NORMAL;                          // Normal and reserved codes
      end
    end
  end
  // Outside reset the mode never moves, whatever the selector does

  assign nand_act = (mode_q == MODE_NAND);

  // Ordinary outputs: core drive in normal mode, released in NAND-tree mode
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      PAD_OUT <= '0;
      PAD_OE  <= '0;
    end else if (nand_act) begin
      PAD_OUT <= '0;
      PAD_OE  <= '0;                                    // All outputs tristated
    end else begin
      PAD_OUT <= CORE_OUT;
      PAD_OE  <= CORE_OE;
    end
  end

  // Serial clock pin: the one output left driven in NAND-tree mode
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      SCL_OUT <= 1'b0;
      SCL_OE  <= 1'b0;
    end else if (nand_act) begin
      SCL_OUT <= nand_res;                              // Tree result on the pin
      SCL_OE  <= 1'b1;                                  // Kept driven
    end else begin
      SCL_OUT <= CORE_SCL_OUT;
      SCL_OE  <= CORE_SCL_OE;
    end
  end

  // Mode status follows the captured mode
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      NAND_MODE <= 1'b0;
    end else begin
      NAND_MODE <= nand_act;
    end
  end

  // Scan clock sampled on the system clock to find its edges
  // Sampled through reset too, so a scan clock parked high gives no false rise at release
  always_ff @(posedge MCLK) begin
    tck_q <= TCK;
  end

  assign tck_rise = TCK & ~tck_q;
  assign tck_fall = ~TCK & tck_q;

  // Undriven mode select reads high, so five scan clocks park the controller in reset
  assign tms_eff = TMS_DRIVEN ? TMS : 1'b1;
  assign tap_rst = SYS_RST | ~TRST_N;                   // Active-low scan reset

  // Standard controller transitions on the mode select level
  always_comb begin
    state_d = state_q;
    case (state_q)
      TAP_RESET:    state_d = tms_eff ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     state_d = tms_eff ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   state_d = tms_eff ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   state_d = tms_eff ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_d = tms_eff ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_d = tms_eff ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_d = tms_eff ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_d = tms_eff ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   state_d = tms_eff ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   state_d = tms_eff ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   state_d = tms_eff ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_d = tms_eff ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_d = tms_eff ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_d = tms_eff ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_d = tms_eff ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   state_d = tms_eff ? TAP_SEL_DR   : TAP_IDLE;
      default:      state_d = TAP_RESET;                // Unused codes recover to reset
    endcase
  end

  // Controller state advances on each rising scan clock
  always_ff @(posedge MCLK) begin
    if (tap_rst) begin
      state_q <= TAP_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // Instruction register: capture, shift from the data input, update
  always_ff @(posedge MCLK) begin
    if (tap_rst) begin
      ir_sr_q <= IR_CAPTURE;
      ir_q    <= INS_IDCODE;
    end else if (tck_rise) begin
      case (state_q)
        TAP_RESET: begin
          ir_q <= INS_IDCODE;                           // Reset selects identification
        end
        TAP_CAP_IR: begin
          ir_sr_q <= IR_CAPTURE;
        end
        TAP_SHIFT_IR: begin
          ir_sr_q <= {TDI, ir_sr_q[IR_WIDTH-1:1]};
        end
        TAP_UPD_IR: begin
          ir_q <= ir_sr_q;
        end
        default: begin
          ir_q <= ir_q;                                 // Hold elsewhere
        end
      endcase
    end
  end

  // Data registers: capture and shift the one the instruction selects
  always_ff @(posedge MCLK) begin
    if (tap_rst) begin
      id_sr_q <= ID_CODE;
      bsr_q   <= '0;
      byp_q   <= 1'b0;
    end else if (tck_rise) begin
      if (state_q == TAP_CAP_DR) begin
        if (ir_q == INS_IDCODE) begin
          id_sr_q <= ID_CODE;
        end else if (ir_q == INS_SAMPLE) begin
          bsr_q <= PIN_IN;                              // Snapshot of the input pins
        end else begin
          byp_q <= 1'b0;                                // Bypass and unknown codes
        end
      end else if (state_q == TAP_SHIFT_DR) begin
        if (ir_q == INS_IDCODE) begin
          id_sr_q <= {TDI, id_sr_q[ID_WIDTH-1:1]};
        end else if (ir_q == INS_SAMPLE) begin
          bsr_q <= {TDI, bsr_q[NAND_WIDTH-1:1]};
        end else begin
          byp_q <= TDI;
        end
      end
    end
  end

  // Serial out of the selected data register
  always_comb begin
    if (ir_q == INS_IDCODE) begin
      dr_bit = id_sr_q[0];
    end else if (ir_q == INS_SAMPLE) begin
      dr_bit = bsr_q[0];
    end else begin
      dr_bit = byp_q;
    end
  end

  // Serial out changes on the falling scan clock, enabled only while shifting
  always_ff @(posedge MCLK) begin
    if (tap_rst) begin
      tdo_val_q <= 1'b0;
      tdo_en_q  <= 1'b0;
    end else if (tck_fall) begin
      if (state_q == TAP_SHIFT_IR) begin
        tdo_val_q <= ir_sr_q[0];
        tdo_en_q  <= 1'b1;
      end else if (state_q == TAP_SHIFT_DR) begin
        tdo_val_q <= dr_bit;
        tdo_en_q  <= 1'b1;
      end else begin
        tdo_en_q  <= 1'b0;
      end
    end
  end

  // Scan data out pin, also released in NAND-tree mode
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      TDO    <= 1'b0;
      TDO_OE <= 1'b0;
    end else begin
      TDO    <= tdo_val_q;
      TDO_OE <= tdo_en_q & ~nand_act;
    end
  end

endmodule
